/* File: design/urt_pkg.sv */
// Shared constants for the serial receive path with timeout and DMA triggers.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package urt_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_RECEIVE_HOLDING_REG = 6'h00;
  localparam logic [5:0] OFS_INTERRUPT_IDENT_REG = 6'h04;
  localparam logic [5:0] OFS_LINE_STATE_REG = 6'h08;
  localparam logic [5:0] OFS_MODEM_STATE_REG = 6'h0C;
  localparam logic [5:0] OFS_ENHANCED_FEATURE_CTRL_TWO = 6'h10;
  localparam logic [5:0] OFS_RX_TIMEOUT_COUNT_LOW = 6'h14;
  localparam logic [5:0] OFS_RX_TIMEOUT_COUNT_HIGH = 6'h18;
  localparam logic [5:0] OFS_FIFO_TRIGGER_LEVEL_REG = 6'h1C;
  localparam logic [5:0] OFS_BAUD_DIVISOR = 6'h20;
  // Field positions
  localparam int ENHANCED_FEATURE_CTRL_TWO_PERIODIC_BIT = 6;
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_OVERRUN_BIT = 1;
  localparam int LSR_FRAMING_BIT = 3;
  localparam int MSR_CTS_BIT = 4;
  localparam int TLR_RX_LSB = 0;
  localparam int TLR_TX_LSB = 8;
  localparam int TLR_FIELD_W = 6;
  // Interrupt identification codes
  localparam logic [3:0] IIR_CODE_NONE = 4'h1;
  localparam logic [3:0] IIR_CODE_RX_TIMEOUT = 4'hC;
  // Reset values
  localparam logic [15:0] DIV_RESET = 16'h001B;
  localparam logic [7:0] TIMEOUT_LOW_RESET = 8'h28;
  localparam logic [7:0] TIMEOUT_HIGH_RESET = 8'h00;
  localparam logic [5:0] TRIG_RESET = 6'h01;
  // Receiver timing: last sample index of a bit and mid-bit sample index
  localparam logic [3:0] SMP_LAST = 4'hF;
  localparam logic [3:0] SMP_MID = 4'h7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } urt_rx_state_e;
endpackage : urt_pkg

/* File: design/urt_fifo_if.sv */
// Carrier between the receive logic and its data FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface urt_fifo_if #(parameter int W = 8, parameter int DEPTH = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [$clog2(DEPTH):0] level;
  modport owner (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, level);
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, level);
endinterface : urt_fifo_if

/* File: design/urt_fifo.sv */
// Synchronous FIFO holding received characters, width and depth as parameters.
// Assumes DEPTH is a power of two and one clock for both ports.
`timescale 1ns/1ps
module urt_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  urt_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } urt_fifo_s;

  urt_fifo_s s_ff;
  urt_fifo_s nxt_s;
  logic do_wr;
  logic do_rd;

  // Handshake flags from the occupancy count
  assign f.wr_ready = (s_ff.count != FULL_COUNT);
  assign f.rd_valid = (s_ff.count != '0);
  assign f.rd_data = s_ff.mem[s_ff.rptr];
  assign f.level = s_ff.count;
  assign do_wr = f.wr_valid && f.wr_ready;
  assign do_rd = f.rd_valid && f.rd_ready;

  // Next state: store, advance pointers, track count
  always_comb
  begin
    nxt_s = s_ff;
    if (do_wr)
    begin
      nxt_s.mem[s_ff.wptr] = f.wr_data;
      nxt_s.wptr = s_ff.wptr + 1'b1;
    end
    if (do_rd)
    begin
      nxt_s.rptr = s_ff.rptr + 1'b1;
    end
    if (do_wr && !do_rd)
    begin
      nxt_s.count = s_ff.count + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      nxt_s.count = s_ff.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end
endmodule : urt_fifo

/* File: design/urt_rx_timeout.sv */
// Serial receiver with receive timeout interrupt and DMA trigger requests.
// Assumes an AXI4-Lite master, an asynchronous serial line and a TX FIFO level on this clock.
`timescale 1ns/1ps
module urt_rx_timeout
  import urt_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int TX_DEPTH = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [5:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic UART_RX_I,
  input wire logic CTS_N_I,
  input wire logic [$clog2(TX_DEPTH):0] TX_FIFO_LEVEL_I,
  output logic DMA_RX_REQ_O,
  output logic DMA_TX_REQ_O,
  output logic RX_TIMEOUT_IRQ_O
);
  import urt_pkg::*;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic cts_meta;
    logic cts_sync;
    logic [15:0] presc;
    logic [3:0] tick16;
    urt_rx_state_e rx_st;
    logic [3:0] smp;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic push;
    logic [7:0] push_data;
    logic overrun;
    logic framing;
    logic [15:0] to_cnt;
    logic to_pend;
    logic periodic;
    logic [7:0] to_lo;
    logic [7:0] to_hi;
    logic [TLR_FIELD_W-1:0] trig_rx;
    logic [TLR_FIELD_W-1:0] trig_tx;
    logic [15:0] div;
    logic aw_held;
    logic [5:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } urt_state_s;

  urt_state_s s_ff;
  urt_state_s nxt_s;
  logic smp_tick;
  logic bit_tick;
  logic ar_take;
  logic [5:0] ar_word;
  logic [5:0] aw_word;
  logic [15:0] to_limit;
  logic to_run;
  logic [TLR_FIELD_W-1:0] rx_level;
  logic [TLR_FIELD_W-1:0] tx_level;
  logic [TLR_FIELD_W-1:0] eff_rx_trig;
  logic [TLR_FIELD_W-1:0] eff_tx_trig;
  logic [TLR_FIELD_W-1:0] tx_room;

  urt_fifo_if #(.W(8), .DEPTH(FIFO_DEPTH)) rxf ();

  urt_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .f(rxf.store)
  );

  // Sample tick from the divisor, bit tick every sixteen samples
  assign smp_tick = (s_ff.presc >= s_ff.div);
  assign bit_tick = smp_tick && (s_ff.tick16 == SMP_LAST);

  // Bus handshakes
  assign S_AXI_AWREADY_O = !s_ff.aw_held && !s_ff.bvalid;
  assign S_AXI_WREADY_O = !s_ff.w_held && !s_ff.bvalid;
  assign S_AXI_ARREADY_O = !s_ff.rvalid;
  assign S_AXI_BVALID_O = s_ff.bvalid;
  assign S_AXI_BRESP_O = s_ff.bresp;
  assign S_AXI_RVALID_O = s_ff.rvalid;
  assign S_AXI_RDATA_O = s_ff.rdata;
  assign S_AXI_RRESP_O = s_ff.rresp;
  assign ar_take = S_AXI_ARVALID_I && !s_ff.rvalid;
  assign ar_word = {S_AXI_ARADDR_I[5:2], 2'b00};
  assign aw_word = {s_ff.aw_addr[5:2], 2'b00};

  // FIFO side: receiver pushes, holding register read pops
  assign rxf.wr_valid = s_ff.push;
  assign rxf.wr_data = s_ff.push_data;
  assign rxf.rd_ready = ar_take && (ar_word == OFS_RECEIVE_HOLDING_REG);

  // Timeout limit from the high and low count registers
  assign to_limit = {s_ff.to_hi, s_ff.to_lo};
  assign to_run = (s_ff.periodic || rxf.rd_valid) && (to_limit != '0);

  // DMA triggers; a zero trigger field acts as one entry
  assign rx_level = TLR_FIELD_W'(rxf.level);
  assign tx_level = TLR_FIELD_W'(TX_FIFO_LEVEL_I);
  assign eff_rx_trig = (s_ff.trig_rx == '0) ? TLR_FIELD_W'(1) : s_ff.trig_rx;
  assign eff_tx_trig = (s_ff.trig_tx == '0) ? TLR_FIELD_W'(1) : s_ff.trig_tx;
  assign tx_room = TLR_FIELD_W'(TX_DEPTH) - tx_level;
  assign DMA_RX_REQ_O = (rx_level >= eff_rx_trig);
  assign DMA_TX_REQ_O = (tx_level <= TLR_FIELD_W'(TX_DEPTH)) && (tx_room >= eff_tx_trig);
  assign RX_TIMEOUT_IRQ_O = s_ff.to_pend;

  // Next state for receiver, timeout and register file
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rx_meta = UART_RX_I;
    nxt_s.rx_sync = s_ff.rx_meta;
    nxt_s.cts_meta = CTS_N_I;
    nxt_s.cts_sync = s_ff.cts_meta;
    nxt_s.push = 1'b0;
    nxt_s.presc = smp_tick ? '0 : s_ff.presc + 16'h0001;
    if (smp_tick)
    begin
      nxt_s.tick16 = s_ff.tick16 + 4'h1;
    end

    // Character receiver, 8 data bits, one stop bit
    unique case (s_ff.rx_st)
      RX_IDLE:
      begin
        if (!s_ff.rx_sync)
        begin
          nxt_s.rx_st = RX_START;
          nxt_s.smp = '0;
        end
      end
      RX_START:
      begin
        if (smp_tick)
        begin
          nxt_s.smp = s_ff.smp + 4'h1;
          if (s_ff.smp == SMP_MID)
          begin
            nxt_s.smp = '0;
            nxt_s.bitn = '0;
            nxt_s.rx_st = s_ff.rx_sync ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (smp_tick)
        begin
          nxt_s.smp = s_ff.smp + 4'h1;
          if (s_ff.smp == SMP_LAST)
          begin
            nxt_s.shreg = {s_ff.rx_sync, s_ff.shreg[7:1]};
            nxt_s.bitn = s_ff.bitn + 3'h1;
            if (s_ff.bitn == 3'h7)
            begin
              nxt_s.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP:
      begin
        if (smp_tick)
        begin
          nxt_s.smp = s_ff.smp + 4'h1;
          if (s_ff.smp == SMP_LAST)
          begin
            nxt_s.push = 1'b1;
            nxt_s.push_data = s_ff.shreg;
            nxt_s.rx_st = RX_IDLE;
          end
        end
      end
    endcase

    // Timeout counter: restarts on a new character, wraps at the limit
    if (s_ff.push || !to_run)
    begin
      nxt_s.to_cnt = '0;
    end
    else if (bit_tick)
    begin
      nxt_s.to_cnt = s_ff.to_cnt + 16'h0001;
    end

    // Register reads; only the identification read touches the timeout flag
    if (ar_take)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = '0;
      unique case (ar_word)
        OFS_RECEIVE_HOLDING_REG: nxt_s.rdata[7:0] = rxf.rd_valid ? rxf.rd_data : 8'h00;
        OFS_INTERRUPT_IDENT_REG:
        begin
          nxt_s.rdata[3:0] = s_ff.to_pend ? IIR_CODE_RX_TIMEOUT : IIR_CODE_NONE;
          nxt_s.to_pend = 1'b0;
        end
        OFS_LINE_STATE_REG:
        begin
          nxt_s.rdata[LSR_DATA_READY_BIT] = rxf.rd_valid;
          nxt_s.rdata[LSR_OVERRUN_BIT] = s_ff.overrun;
          nxt_s.rdata[LSR_FRAMING_BIT] = s_ff.framing;
          nxt_s.overrun = 1'b0;
          nxt_s.framing = 1'b0;
        end
        OFS_MODEM_STATE_REG: nxt_s.rdata[MSR_CTS_BIT] = !s_ff.cts_sync;
        OFS_ENHANCED_FEATURE_CTRL_TWO: nxt_s.rdata[ENHANCED_FEATURE_CTRL_TWO_PERIODIC_BIT] = s_ff.periodic;
        OFS_RX_TIMEOUT_COUNT_LOW: nxt_s.rdata[7:0] = s_ff.to_lo;
        OFS_RX_TIMEOUT_COUNT_HIGH: nxt_s.rdata[7:0] = s_ff.to_hi;
        OFS_FIFO_TRIGGER_LEVEL_REG:
        begin
          nxt_s.rdata[TLR_RX_LSB +: TLR_FIELD_W] = s_ff.trig_rx;
          nxt_s.rdata[TLR_TX_LSB +: TLR_FIELD_W] = s_ff.trig_tx;
        end
        OFS_BAUD_DIVISOR: nxt_s.rdata[15:0] = s_ff.div;
        default: nxt_s.rresp = RESP_SLVERR;
      endcase
    end
    else if (S_AXI_RREADY_I)
    begin
      nxt_s.rvalid = 1'b0;
    end

    // Timeout event sets the flag, winning over a same-cycle clear
    if (to_run && bit_tick && !s_ff.push && (s_ff.to_cnt + 16'h0001 >= to_limit))
    begin
      nxt_s.to_cnt = '0;
      nxt_s.to_pend = 1'b1;
    end

    // Error flags, set wins over the line-state read clear
    if (s_ff.push && !rxf.wr_ready)
    begin
      nxt_s.overrun = 1'b1;
    end
    if (s_ff.rx_st == RX_STOP && smp_tick && s_ff.smp == SMP_LAST && !s_ff.rx_sync)
    begin
      nxt_s.framing = 1'b1;
    end

    // Write address and data are captured in either order
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = S_AXI_WDATA_I;
      nxt_s.w_strb = S_AXI_WSTRB_I;
    end
    if (s_ff.aw_held && s_ff.w_held)
    begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      unique case (aw_word)
        OFS_RECEIVE_HOLDING_REG, OFS_INTERRUPT_IDENT_REG, OFS_LINE_STATE_REG, OFS_MODEM_STATE_REG:
        begin
          nxt_s.bresp = RESP_OKAY;
        end
        OFS_ENHANCED_FEATURE_CTRL_TWO:
        begin
          if (s_ff.w_strb[0])
          begin
            nxt_s.periodic = s_ff.w_data[ENHANCED_FEATURE_CTRL_TWO_PERIODIC_BIT];
          end
        end
        OFS_RX_TIMEOUT_COUNT_LOW:
        begin
          if (s_ff.w_strb[0])
          begin
            nxt_s.to_lo = s_ff.w_data[7:0];
          end
        end
        OFS_RX_TIMEOUT_COUNT_HIGH:
        begin
          if (s_ff.w_strb[0])
          begin
            nxt_s.to_hi = s_ff.w_data[7:0];
          end
        end
        OFS_FIFO_TRIGGER_LEVEL_REG:
        begin
          if (s_ff.w_strb[0])
          begin
            nxt_s.trig_rx = s_ff.w_data[TLR_RX_LSB +: TLR_FIELD_W];
          end
          if (s_ff.w_strb[1])
          begin
            nxt_s.trig_tx = s_ff.w_data[TLR_TX_LSB +: TLR_FIELD_W];
          end
        end
        OFS_BAUD_DIVISOR:
        begin
          if (s_ff.w_strb[0])
          begin
            nxt_s.div[7:0] = s_ff.w_data[7:0];
          end
          if (s_ff.w_strb[1])
          begin
            nxt_s.div[15:8] = s_ff.w_data[15:8];
          end
        end
        default: nxt_s.bresp = RESP_SLVERR;
      endcase
    end
    else if (s_ff.bvalid && S_AXI_BREADY_I)
    begin
      nxt_s.bvalid = 1'b0;
    end
  end

  // State register with reset values
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_ff <= '0;
      s_ff.rx_meta <= 1'b1;
      s_ff.rx_sync <= 1'b1;
      s_ff.cts_meta <= 1'b1;
      s_ff.cts_sync <= 1'b1;
      s_ff.div <= DIV_RESET;
      s_ff.to_lo <= TIMEOUT_LOW_RESET;
      s_ff.to_hi <= TIMEOUT_HIGH_RESET;
      s_ff.trig_rx <= TRIG_RESET;
      s_ff.trig_tx <= TRIG_RESET;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end
endmodule : urt_rx_timeout

/* File: testbench/urt_serial_src.sv */
// Remote serial transmitter model driving the receive line.
// Assumes 8N1 framing and a bit time of BIT_CLKS clocks.
`timescale 1ns/1ps
module urt_serial_src #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  output logic line_o
);
  // Line rests high between frames
  initial line_o = 1'h1;

  // Start bit, data LSB first, stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      line_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  endtask : send
endmodule : urt_serial_src

/* File: testbench/urt_rx_timeout_sva.sv */
// Port-level checks of the receive timeout block, bound into it.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ps
module urt_rx_timeout_chk
  import urt_pkg::*;
#(
  parameter int TX_DEPTH = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [$clog2(TX_DEPTH):0] TX_FIFO_LEVEL_I,
  input wire logic DMA_TX_REQ_O,
  input wire logic RX_TIMEOUT_IRQ_O
);
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  // Read request taken, and its word address
  wire logic take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire logic [3:0] wa = S_AXI_ARADDR_I[5:2];
  wire logic interrupt_ident_reg = take && (wa == OFS_INTERRUPT_IDENT_REG[5:2]);

  ar_answer_a: assert property (take |=> S_AXI_RVALID_O)
    else $error("read not answered next cycle");
  ar_block_a: assert property (S_AXI_ARREADY_O != S_AXI_RVALID_O)
    else $error("read ready not inverse of valid");
  r_once_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
    else $error("read data kept after accept");
  b_block_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
    else $error("write address taken with response pending");
  ident_code_a: assert property (interrupt_ident_reg |=> S_AXI_RDATA_O[3:0] ==
    ($past(RX_TIMEOUT_IRQ_O) ? IIR_CODE_RX_TIMEOUT : IIR_CODE_NONE))
    else $error("identification code wrong");
  irq_clear_a: assert property ($fell(RX_TIMEOUT_IRQ_O) |-> $past(interrupt_ident_reg))
    else $error("timeout flag dropped without ident read");
  read_keep_a: assert property (take && (wa == 4'h0 || wa == 4'h2 || wa == 4'h3)
    && RX_TIMEOUT_IRQ_O |=> RX_TIMEOUT_IRQ_O)
    else $error("status read cleared timeout flag");
  tx_full_a: assert property (TX_FIFO_LEVEL_I == TX_DEPTH |-> !DMA_TX_REQ_O)
    else $error("transmit request with no free space");
endmodule : urt_rx_timeout_chk

bind urt_rx_timeout urt_rx_timeout_chk #(.TX_DEPTH(TX_DEPTH)) chk_i (
  .REF_CLK_I(REF_CLK_I),
  .RST_I(RST_I),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .TX_FIFO_LEVEL_I(TX_FIFO_LEVEL_I),
  .DMA_TX_REQ_O(DMA_TX_REQ_O),
  .RX_TIMEOUT_IRQ_O(RX_TIMEOUT_IRQ_O)
);

/* File: testbench/tb_top.sv */
// Self-checking bench for the receive timeout and DMA trigger block.
// Assumes the serial source model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import urt_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic [3:0] txlvl = 4'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'h0;
  logic rready = 1'h0;
  logic cts_n = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_line, rxreq, txreq, irq, seen;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  urt_serial_src #(.BIT_CLKS(16)) src (.clk_i(clk), .line_o(rx_line));
  urt_rx_timeout #(.FIFO_DEPTH(8), .TX_DEPTH(8)) uut (
    .REF_CLK_I(clk),
    .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready),
    .UART_RX_I(rx_line),
    .CTS_N_I(cts_n),
    .TX_FIFO_LEVEL_I(txlvl),
    .DMA_RX_REQ_O(rxreq),
    .DMA_TX_REQ_O(txreq),
    .RX_TIMEOUT_IRQ_O(irq)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Bus write: address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic at;
    logic wt;
    at = 1'h0;
    wt = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(at && wt))
    begin
      @(posedge clk);
      at = at | (awvalid & awready);
      wt = wt | (wvalid & wready);
      if (at)
        awvalid <= 1'h0;
      if (wt)
        wvalid <= 1'h0;
    end
    // Accept the response only once both halves are taken
    bready <= 1'h1;
    do @(posedge clk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rv = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rd

  // Window scan, stops at the first raised flag
  task automatic watch(input int n);
    seen = 1'h0;
    for (int k = 0; k < n && !seen; k++)
    begin
      @(posedge clk);
      seen = irq;
    end
  endtask : watch

  task automatic t_reset();
    logic [5:0] a[7] = '{6'h04, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h0C};
    logic [31:0] e[7] = '{32'h1, 32'h0, 32'h28, 32'h0, 32'h101, 32'h1B, 32'h10};
    for (int i = 0; i < 7; i++)
    begin
      rd(a[i]);
      chk(rv, e[i]);
    end
    rd(6'h24);
    chk(resp, RESP_SLVERR);
    wr(6'h24, 32'h1);
    chk(resp, RESP_SLVERR);
    wr(6'h04, 32'h0);
    chk(resp, RESP_OKAY);
    // Lane 1 only: transmit trigger changes, receive trigger kept
    wstrb <= 4'h2;
    wr(6'h1C, 32'h0505);
    wstrb <= 4'hF;
    rd(6'h1C);
    chk(rv, 32'h0501);
    // Deasserted clear-to-send shows through the synchroniser
    cts_n <= 1'h1;
    repeat (3) @(posedge clk);
    rd(6'h0C);
    chk(rv, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_orig();
    wr(6'h14, 32'h4);
    src.send(8'h5A);
    watch(200);
    chk(seen, 1'h1);
    rd(6'h08);
    chk(rv[0], 1'h1);
    rd(6'h0C);
    chk(irq, 1'h1);
    rd(6'h04);
    chk(rv[3:0], IIR_CODE_RX_TIMEOUT);
    chk(irq, 1'h0);
    watch(100);
    chk(seen, 1'h1);
    rd(6'h00);
    chk(rv, 32'h5A);
    rd(6'h04);
    watch(150);
    chk(seen, 1'h0);
    $display("original mode test done");
  endtask : t_orig

  task automatic t_per();
    wr(6'h10, 32'h40);
    rd(6'h10);
    chk(rv, 32'h40);
    wr(6'h14, 32'h3);
    watch(100);
    chk(seen, 1'h1);
    rd(6'h04);
    watch(20);
    chk(seen, 1'h0);
    watch(60);
    chk(seen, 1'h1);
    wr(6'h18, 32'h1);
    rd(6'h04);
    watch(200);
    chk(seen, 1'h0);
    wr(6'h10, 32'h0);
    wr(6'h18, 32'h0);
    rd(6'h04);
    watch(150);
    chk(seen, 1'h0);
    $display("periodic mode test done");
  endtask : t_per

  task automatic t_trig();
    logic [5:0] t[4] = '{6'h1, 6'h2, 6'h4, 6'h8};
    foreach (t[j])
    begin
      wr(6'h1C, {18'h0, t[j], 2'h0, t[j]});
      for (int k = 1; k <= t[j] + (t[j] == 6'h8); k++)
      begin
        src.send(8'hA0 + k[7:0]);
        repeat (6) @(posedge clk);
        chk(rxreq, k >= t[j]);
      end
      for (int l = 0; l <= 8; l++)
      begin
        txlvl <= l[3:0];
        @(posedge clk);
        chk(txreq, 8 - l >= t[j]);
      end
      rd(6'h08);
      chk(rv[1], t[j] == 6'h8);
      for (int k = 1; k <= t[j]; k++)
      begin
        rd(6'h00);
        chk(rv, 32'hA0 + k);
      end
      rd(6'h00);
      chk(rv, 32'h0);
      chk(rxreq, 1'h0);
    end
    $display("trigger test done");
  endtask : t_trig

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    wr(6'h20, 32'h0);
    t_orig();
    t_per();
    t_trig();
    results();
  end
endmodule : tb_top
